// >>> core/pfm_regs.svh
// Purpose: constants for the pin function multiplexer
// Assumes: included by bare name from core files
// Notes: pin index n of the parallel bank is display data n-1 for n in 1..16
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH
// reset values of the selection and pulldown inhibit registers
`define PFM_EBS_PAR_RST 3'h0
`define PFM_EBS_SER_RST 2'h0
`define PFM_PDI_PAR_RST 14'h0000
`define PFM_PDI_SER_RST 6'h00
// bank widths
`define PFM_PP_PINS 21
`define PFM_SP_PINS 6
// parallel bank pin positions
`define PFM_PIN_EN 0
`define PFM_PIN_D0 1
`define PFM_PIN_D8 9
`define PFM_PIN_D12 13
`define PFM_PIN_D15 16
`define PFM_PIN_RS 20
// pulldown inhibit fields: parallel bits cover data 2..15, serial bits cover clk..data 3
`define PFM_PD_DATA2 0
`define PFM_PD_DATA8 6
`define PFM_PD_DATA15 13
`define PFM_PD_SD_DATA2 4
// first parallel pin that has a pulldown inhibit field
`define PFM_PD_FIRST_PIN 3
`endif

// >>> core/pfm_pkg.sv
// Purpose: types for the pin function multiplexer
// Assumes: nothing
// Notes: mode codes follow the selection register fields
package pfm_pkg;
	typedef enum logic [2:0] {
		PFM_PP_DISP = 3'b000,
		PFM_PP_SPI_GPIO = 3'b001,
		PFM_PP_GPIO = 3'b010,
		PFM_PP_SPI_I2S3 = 3'b011,
		PFM_PP_I2S2_UART = 3'b100,
		PFM_PP_SPI_UART = 3'b101,
		PFM_PP_SPI_I2S = 3'b110,
		PFM_PP_RSVD = 3'b111
	} pfm_par_mode_t;
	typedef enum logic [1:0] {
		PFM_SP_CARD = 2'b00,
		PFM_SP_AUDIO = 2'b01,
		PFM_SP_GPIO = 2'b10,
		PFM_SP_RSVD = 2'b11
	} pfm_ser_mode_t;
	// owner of a group of four display data pins
	typedef enum logic [1:0] {
		PFM_HS_DISP = 2'b00,
		PFM_HS_PERA = 2'b01,
		PFM_HS_GPIO = 2'b10,
		PFM_HS_PERB = 2'b11
	} pfm_hi_sel_t;
endpackage : pfm_pkg

// >>> core/pfm_pad_bank.sv
// Purpose: pad-side flops for one bank of shared pins
// Assumes: pin inputs are asynchronous to core_clk
// Notes: output enable is active low at the pin
`timescale 1ns/100ps
`default_nettype none
module pfm_pad_bank #(
	parameter int W = 6
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] pin_i,
	input wire logic [W-1:0] out_d,
	input wire logic [W-1:0] oe_d,
	output logic [W-1:0] pin_o,
	output logic [W-1:0] pin_oe_n,
	output logic [W-1:0] sync_q
);
	logic [W-1:0] meta_r;
	// two-stage synchroniser; only the second stage is read by the mux
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_r <= '0;
			sync_q <= '0;
		end else if (ce) begin
			meta_r <= pin_i;
			sync_q <= meta_r;
		end
	end
	// registered drive so every pin switches on the same edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_o <= '0;
			pin_oe_n <= '1; // released until the mux has settled
		end else if (ce) begin
			pin_o <= out_d;
			pin_oe_n <= ~oe_d;
		end
	end
endmodule : pfm_pad_bank
`default_nettype wire

// >>> core/pfm_mux.sv
// Purpose: route shared pins between display, spi, uart, audio, card and gpio
// Assumes: peripherals sit on core_clk; pins are asynchronous
// Notes: peripheral inputs of unowned functions read idle levels
// Summary of operation
// - only the selection register changes pin ownership
// - parallel field resets to 000, all display
// - mode 001: spi, gpio 12-17, audio2, uart
// - mode 010: data 8-15 become gpio
// - mode 011: data 8-11 spi, 12-15 audio3
// - 100 audio2+uart; 101 spi+uart on data 8-15
// - mode 110: spi, gpio 12-17, audio2, audio3
// - serial field: 00 card, 01 audio1, 10 gpio
// - card data 2-3 are gpio 10-11 in 01/10
// - pulldown inhibit bits act regardless of mode
`timescale 1ns/100ps
`default_nettype none
`include "pfm_regs.svh"
module pfm_mux (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic ebs_wr_en,
	input wire logic [2:0] ebs_wr_par,
	input wire logic [1:0] ebs_wr_ser,
	input wire logic pdi_wr_en,
	input wire logic [13:0] pdi_wr_par,
	input wire logic [5:0] pdi_wr_ser,
	output logic [2:0] parallel_port_mux_field,
	output logic [1:0] serial_port1_mux_field,
	output logic [13:0] pulldown_inhibit_reg_c,
	output logic [5:0] serial_pd_inhibit,
	input wire logic [20:0] pp_pin_i,
	output logic [20:0] pp_pin_o,
	output logic [20:0] pp_pin_oe_n,
	input wire logic [5:0] sp_pin_i,
	output logic [5:0] sp_pin_o,
	output logic [5:0] sp_pin_oe_n,
	input wire logic [20:0] disp_out,
	input wire logic [20:0] disp_oe,
	output logic [20:0] disp_in,
	input wire logic spi_clk_o,
	input wire logic spi_tx_o,
	input wire logic [3:0] spi_cs_o,
	output logic spi_rx_i,
	input wire logic uart_rts_o,
	input wire logic uart_txd_o,
	output logic uart_cts_i,
	output logic uart_rxd_i,
	input wire logic [2:0] i2s1_o,
	input wire logic [1:0] i2s1_oe,
	output logic [2:0] i2s1_i,
	input wire logic [2:0] i2s2_o,
	input wire logic [1:0] i2s2_oe,
	output logic [2:0] i2s2_i,
	input wire logic [2:0] i2s3_o,
	input wire logic [1:0] i2s3_oe,
	output logic [2:0] i2s3_i,
	input wire logic card_clk_o,
	input wire logic card_cmd_o,
	input wire logic card_cmd_oe,
	input wire logic [3:0] card_dat_o,
	input wire logic [3:0] card_dat_oe,
	output logic card_cmd_i,
	output logic [3:0] card_dat_i,
	input wire logic [31:0] gpio_out,
	input wire logic [31:0] gpio_oe,
	output logic [31:0] gpio_in
);
	// audio ports: bit 0 clock, bit 1 frame sync, bit 2 transmit (out) / receive (in)
	logic [2:0] par_r;
	logic [1:0] ser_r;
	logic [20:0] pp_sync;
	logic [5:0] sp_sync;
	logic [69:0] per_in_r;
	function automatic pfm_pkg::pfm_hi_sel_t low_nib_sel(input pfm_pkg::pfm_par_mode_t m);
		unique case (m)
			pfm_pkg::PFM_PP_SPI_GPIO, pfm_pkg::PFM_PP_I2S2_UART,
			pfm_pkg::PFM_PP_SPI_I2S: low_nib_sel = pfm_pkg::PFM_HS_PERA;
			pfm_pkg::PFM_PP_GPIO: low_nib_sel = pfm_pkg::PFM_HS_GPIO;
			pfm_pkg::PFM_PP_SPI_I2S3, pfm_pkg::PFM_PP_SPI_UART: low_nib_sel = pfm_pkg::PFM_HS_PERB;
			pfm_pkg::PFM_PP_DISP, pfm_pkg::PFM_PP_RSVD: low_nib_sel = pfm_pkg::PFM_HS_DISP;
		endcase
	endfunction : low_nib_sel
	function automatic pfm_pkg::pfm_hi_sel_t high_nib_sel(input pfm_pkg::pfm_par_mode_t m);
		unique case (m)
			pfm_pkg::PFM_PP_SPI_GPIO, pfm_pkg::PFM_PP_I2S2_UART,
			pfm_pkg::PFM_PP_SPI_UART: high_nib_sel = pfm_pkg::PFM_HS_PERA;
			pfm_pkg::PFM_PP_GPIO: high_nib_sel = pfm_pkg::PFM_HS_GPIO;
			pfm_pkg::PFM_PP_SPI_I2S3, pfm_pkg::PFM_PP_SPI_I2S: high_nib_sel = pfm_pkg::PFM_HS_PERB;
			pfm_pkg::PFM_PP_DISP, pfm_pkg::PFM_PP_RSVD: high_nib_sel = pfm_pkg::PFM_HS_DISP;
		endcase
	endfunction : high_nib_sel
	function automatic logic [3:0] mux4(input pfm_pkg::pfm_hi_sel_t s, input logic [3:0] d,
			input logic [3:0] a, input logic [3:0] g, input logic [3:0] b);
		unique case (s)
			pfm_pkg::PFM_HS_DISP: mux4 = d;
			pfm_pkg::PFM_HS_PERA: mux4 = a;
			pfm_pkg::PFM_HS_GPIO: mux4 = g;
			pfm_pkg::PFM_HS_PERB: mux4 = b;
		endcase
	endfunction : mux4
	// the selection register is the sole owner control; reset at any ce level
	always_ff @(posedge core_clk) begin
		if (rst) begin
			par_r <= `PFM_EBS_PAR_RST;
			ser_r <= `PFM_EBS_SER_RST;
		end else if (ce && ebs_wr_en) begin
			par_r <= ebs_wr_par;
			ser_r <= ebs_wr_ser;
		end
	end
	// pulldown inhibit is stored apart from the mode so a mux change never touches it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pulldown_inhibit_reg_c <= `PFM_PDI_PAR_RST;
			serial_pd_inhibit <= `PFM_PDI_SER_RST;
		end else if (ce && pdi_wr_en) begin
			pulldown_inhibit_reg_c <= pdi_wr_par;
			serial_pd_inhibit <= pdi_wr_ser;
		end
	end
	assign parallel_port_mux_field = par_r;
	assign serial_port1_mux_field = ser_r;
	// reserved codes read back as written but route like reset
	wire pfm_pkg::pfm_par_mode_t eff_par = (par_r == pfm_pkg::PFM_PP_RSVD) ?
		pfm_pkg::PFM_PP_DISP : pfm_pkg::pfm_par_mode_t'(par_r);
	wire pfm_pkg::pfm_ser_mode_t eff_ser = (ser_r == pfm_pkg::PFM_SP_RSVD) ?
		pfm_pkg::PFM_SP_CARD : pfm_pkg::pfm_ser_mode_t'(ser_r);
	wire ctl_spi = (eff_par == pfm_pkg::PFM_PP_SPI_GPIO) ||
		(eff_par == pfm_pkg::PFM_PP_SPI_I2S);
	wire pfm_pkg::pfm_hi_sel_t ln = low_nib_sel(eff_par);
	wire pfm_pkg::pfm_hi_sel_t hn = high_nib_sel(eff_par);
	// control pins: bits 2:0 enable, data 0, data 1; bits 6:3 the four selects
	wire [6:0] ctl_o = ctl_spi ? {spi_cs_o, spi_tx_o, 1'b0, spi_clk_o} :
		{disp_out[20:17], disp_out[2:0]};
	wire [6:0] ctl_oe = ctl_spi ? 7'h7d : {disp_oe[20:17], disp_oe[2:0]};
	wire [5:0] lo_o = ctl_spi ? gpio_out[17:12] : disp_out[8:3];
	wire [5:0] lo_oe = ctl_spi ? gpio_oe[17:12] : disp_oe[8:3];
	// data 8-11: audio 2, gpio 18-20/27 or spi
	wire [3:0] ln_o = mux4(ln, disp_out[12:9], {i2s2_o[2], 1'b0, i2s2_o[1:0]},
		{gpio_out[27], gpio_out[20:18]}, {spi_tx_o, 1'b0, spi_cs_o[0], spi_clk_o});
	wire [3:0] ln_oe = mux4(ln, disp_oe[12:9], {2'b10, i2s2_oe},
		{gpio_oe[27], gpio_oe[20:18]}, 4'hb);
	// data 12-15: uart, gpio 28-31 or audio 3
	wire [3:0] hn_o = mux4(hn, disp_out[16:13], {uart_txd_o, 2'b00, uart_rts_o},
		gpio_out[31:28], {i2s3_o[2], 1'b0, i2s3_o[1:0]});
	wire [3:0] hn_oe = mux4(hn, disp_oe[16:13], 4'h9, gpio_oe[31:28], {2'b10, i2s3_oe});
	wire [20:0] pp_out_d = {ctl_o[6:3], hn_o, ln_o, lo_o, ctl_o[2:0]};
	wire [20:0] pp_oe_d = {ctl_oe[6:3], hn_oe, ln_oe, lo_oe, ctl_oe[2:0]};
	// serial bank: the audio port needs four pins, so data 2-3 fall to gpio
	wire ser_card = (eff_ser == pfm_pkg::PFM_SP_CARD);
	wire ser_aud = (eff_ser == pfm_pkg::PFM_SP_AUDIO);
	wire [5:0] sp_out_d = ser_card ? {card_dat_o, card_cmd_o, card_clk_o} :
		ser_aud ? {gpio_out[11:10], 1'b0, i2s1_o[2], i2s1_o[1:0]} :
		gpio_out[11:6];
	wire [5:0] sp_oe_d = ser_card ? {card_dat_oe, card_cmd_oe, 1'b1} :
		ser_aud ? {gpio_oe[11:10], 2'b01, i2s1_oe} : gpio_oe[11:6];
	pfm_pad_bank #(.W(`PFM_PP_PINS)) u_pp_pads (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.pin_i(pp_pin_i),
		.out_d(pp_out_d),
		.oe_d(pp_oe_d),
		.pin_o(pp_pin_o),
		.pin_oe_n(pp_pin_oe_n),
		.sync_q(pp_sync)
	);
	pfm_pad_bank #(.W(`PFM_SP_PINS)) u_sp_pads (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.pin_i(sp_pin_i),
		.out_d(sp_out_d),
		.oe_d(sp_oe_d),
		.pin_o(sp_pin_o),
		.pin_oe_n(sp_pin_oe_n),
		.sync_q(sp_sync)
	);
	// input routing; unowned inputs read idle so a detached peripheral sees no edges
	wire [20:0] disp_own = {{4{~ctl_spi}}, {4{hn == pfm_pkg::PFM_HS_DISP}},
		{4{ln == pfm_pkg::PFM_HS_DISP}}, {6{~ctl_spi}}, {3{~ctl_spi}}};
	wire sp_gp = ~ser_card;
	wire [31:0] gpio_in_nxt = {
		(hn == pfm_pkg::PFM_HS_GPIO) ? pp_sync[16:13] : 4'h0,
		(ln == pfm_pkg::PFM_HS_GPIO) ? pp_sync[12] : 1'b0, 6'h00,
		(ln == pfm_pkg::PFM_HS_GPIO) ? pp_sync[11:9] : 3'h0,
		ctl_spi ? pp_sync[8:3] : 6'h00,
		sp_gp ? sp_sync[5:4] : 2'h0,
		(eff_ser == pfm_pkg::PFM_SP_GPIO) ? sp_sync[3:0] : 4'h0, 6'h00};
	wire spi_rx_nxt = ctl_spi ? pp_sync[1] : ((ln == pfm_pkg::PFM_HS_PERB) & pp_sync[11]);
	wire [1:0] uart_nxt = (hn == pfm_pkg::PFM_HS_PERA) ? {pp_sync[15], pp_sync[14]} : 2'b10;
	wire [2:0] i2s2_nxt = (ln == pfm_pkg::PFM_HS_PERA) ? pp_sync[11:9] : 3'h0;
	wire [2:0] i2s3_nxt = (hn == pfm_pkg::PFM_HS_PERB) ? {pp_sync[15], pp_sync[14:13]} : 3'h0;
	wire [2:0] i2s1_nxt = ser_aud ? {sp_sync[3], sp_sync[1:0]} : 3'h0;
	wire [4:0] card_nxt = ser_card ? sp_sync[5:1] : 5'h00;
	wire [69:0] per_in_nxt = {pp_sync & disp_own, gpio_in_nxt, spi_rx_nxt, uart_nxt,
		i2s2_nxt, i2s3_nxt, i2s1_nxt, card_nxt};
	// one register stage so peripheral inputs switch owner in step with the pins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			per_in_r <= {21'h000000, 32'h00000000, 1'b0, 2'b10, 14'h0000};
		end else if (ce) begin
			per_in_r <= per_in_nxt;
		end
	end
	assign disp_in = per_in_r[69:49];
	assign gpio_in = per_in_r[48:17];
	assign spi_rx_i = per_in_r[16];
	assign uart_rxd_i = per_in_r[15];
	assign uart_cts_i = per_in_r[14];
	assign i2s2_i = per_in_r[13:11];
	assign i2s3_i = per_in_r[10:8];
	assign i2s1_i = per_in_r[7:5];
	assign card_dat_i = per_in_r[4:1];
	assign card_cmd_i = per_in_r[0];
	// checks on the routing
	a_reset_mode_default: assert property (@(posedge core_clk) $fell(rst) |->
		par_r == 3'h0 && ser_r == 2'h0) else $error("mode not default after reset");
	// the pad stage only moves on an enabled edge, so a frozen cycle skips the pin check
	a_mode_write_land: assert property (@(posedge core_clk) disable iff (rst)
		ce && ebs_wr_en |=> par_r == $past(ebs_wr_par)
		##1 (!$past(ce) || pp_pin_o == $past(pp_out_d)))
		else $error("mode write not applied");
	a_mode_only_reg: assert property (@(posedge core_clk) disable iff (rst)
		!(ce && ebs_wr_en) |=> $stable(par_r) && $stable(ser_r))
		else $error("mode changed without write");
	a_mode1_spi_ctl: assert property (@(posedge core_clk) disable iff (rst)
		ce && par_r == 3'h1 |=> pp_pin_o[0] == $past(spi_clk_o) && pp_pin_oe_n[1]
		&& pp_pin_o[16] == $past(uart_txd_o)) else $error("mode 1 routing wrong");
	a_mode2_gpio_hi: assert property (@(posedge core_clk) disable iff (rst)
		ce && par_r == 3'h2 |=> pp_pin_o[16:9] == $past({gpio_out[31:27], gpio_out[20:18]})
		&& pp_pin_o[0] == $past(disp_out[0])) else $error("mode 2 routing wrong");
	a_mode3_audio3: assert property (@(posedge core_clk) disable iff (rst)
		ce && par_r == 3'h3 |=> pp_pin_o[13] == $past(i2s3_o[0])
		&& pp_pin_o[10] == $past(spi_cs_o[0])) else $error("mode 3 routing wrong");
	a_mode45_uart: assert property (@(posedge core_clk) disable iff (rst)
		ce && (par_r == 3'h4 || par_r == 3'h5) |=> pp_pin_o[16] == $past(uart_txd_o)
		&& pp_pin_o[20] == $past(disp_out[20])) else $error("mode 4/5 routing wrong");
	a_mode6_spi_i2s: assert property (@(posedge core_clk) disable iff (rst)
		ce && par_r == 3'h6 |=> pp_pin_o[20] == $past(spi_cs_o[3])
		&& pp_pin_o[8:3] == $past(gpio_out[17:12])) else $error("mode 6 routing wrong");
	a_ser_gpio_route: assert property (@(posedge core_clk) disable iff (rst)
		ce && ser_r != 2'h0 && ser_r != 2'h3 |=> sp_pin_o[5:4] == $past(gpio_out[11:10]))
		else $error("card data 2-3 not gpio");
	a_reserved_default: assert property (@(posedge core_clk) disable iff (rst)
		ce && par_r == 3'h7 |=> pp_pin_o == $past(disp_out))
		else $error("reserved not default");
	a_pd_independent: assert property (@(posedge core_clk) disable iff (rst)
		ce && ebs_wr_en && !pdi_wr_en |=> $stable(pulldown_inhibit_reg_c))
		else $error("pulldown moved with mode");
endmodule : pfm_mux
`default_nettype wire

// >>> verif/pfm_board_model.sv
// Purpose: board side of the shared pins of the pin function multiplexer
// Assumes: phase input comes from the bench and flips the termination pattern
// Notes: the board drives a pin only while the mux leaves it undriven
`timescale 1ns/100ps
`default_nettype none
module pfm_board_model (
	input wire logic p,
	input wire logic [20:0] pp_pin_o,
	input wire logic [20:0] pp_pin_oe_n,
	input wire logic [5:0] sp_pin_o,
	input wire logic [5:0] sp_pin_oe_n,
	output logic [20:0] pp_ext,
	output logic [5:0] sp_ext,
	output logic [20:0] pp_pin_i,
	output logic [5:0] sp_pin_i
);
	// terminations flip with phase so each pin is seen at both levels
	assign pp_ext = {21{p}} ^ 21'h0b2d4e;
	assign sp_ext = {6{p}} ^ 6'h2b;
	// wire level: the enabled mux driver wins, else the board, never floating
	assign pp_pin_i = (pp_pin_oe_n & pp_ext) | (~pp_pin_oe_n & pp_pin_o);
	assign sp_pin_i = (sp_pin_oe_n & sp_ext) | (~sp_pin_oe_n & sp_pin_o);
endmodule : pfm_board_model
`default_nettype wire

// >>> verif/pin_function_mux_tb.sv
// Purpose: self-checking bench for the pin function multiplexer
// Assumes: peripheral outputs are patterns of the phase bit p
// Notes: pin values are compared only where the pin is expected to drive
`timescale 1ns/100ps
`default_nettype none
module pin_function_mux_tb;
	localparam int GPH [8] = '{18, 19, 20, 27, 28, 29, 30, 31};
	localparam int SLO [4] = '{0, 3, 1, 2};
	localparam int SAU [4] = '{0, 1, 3, 2};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic p = 1'b0;
	logic ebs_wr_en = 1'b0;
	logic pdi_wr_en = 1'b0;
	logic [2:0] ebs_wr_par = 3'h0;
	logic [1:0] ebs_wr_ser = 2'h0;
	logic [13:0] pdi_wr_par = 14'h0000;
	logic [5:0] pdi_wr_ser = 6'h00;
	logic [2:0] pm = 3'h0;
	logic [1:0] ps = 2'h0;
	int num_errors = 0;
	int check_count = 0;
	int cycle_cnt = 0;
	logic [2:0] parallel_port_mux_field, i2s1_i, i2s2_i, i2s3_i;
	logic [1:0] serial_port1_mux_field;
	logic [13:0] pulldown_inhibit_reg_c;
	logic [20:0] pp_pin_i, pp_pin_o, pp_pin_oe_n, disp_in, pp_ext;
	logic [5:0] serial_pd_inhibit, sp_pin_i, sp_pin_o, sp_pin_oe_n, sp_ext;
	logic spi_rx_i, uart_cts_i, uart_rxd_i, card_cmd_i;
	logic [3:0] card_dat_i;
	logic [31:0] gpio_in;
	// peripheral drives; every output and enable is a fixed pattern flipped by p
	wire logic [20:0] disp_out = {21{p}} ^ 21'h155555;
	wire logic [20:0] disp_oe = {21{p}} ^ 21'h0f0f0f;
	wire logic [31:0] gpio_out = {32{p}} ^ 32'h5a5a5a5a;
	wire logic [31:0] gpio_oe = {32{p}} ^ 32'h3c3c3c3c;
	wire logic [3:0] spi_cs_o = {4{p}} ^ 4'h5;
	wire logic [2:0] i2s1_o = {3{p}} ^ 3'h5;
	wire logic [2:0] i2s2_o = {3{p}} ^ 3'h3;
	wire logic [2:0] i2s3_o = {3{p}} ^ 3'h6;
	wire logic [1:0] i2s1_oe = {2{p}} ^ 2'h1;
	wire logic [1:0] i2s2_oe = {2{p}} ^ 2'h2;
	wire logic [1:0] i2s3_oe = {2{p}} ^ 2'h3;
	wire logic [3:0] card_dat_o = {4{p}} ^ 4'h9;
	wire logic [3:0] card_dat_oe = {4{p}} ^ 4'h6;

	pfm_mux DUT (.core_clk, .rst, .ce, .ebs_wr_en, .ebs_wr_par, .ebs_wr_ser, .pdi_wr_en,
		.pdi_wr_par, .pdi_wr_ser, .parallel_port_mux_field, .serial_port1_mux_field,
		.pulldown_inhibit_reg_c, .serial_pd_inhibit, .pp_pin_i, .pp_pin_o, .pp_pin_oe_n,
		.sp_pin_i, .sp_pin_o, .sp_pin_oe_n, .disp_out, .disp_oe, .disp_in, .spi_clk_o(~p),
		.spi_tx_o(p), .spi_cs_o, .spi_rx_i, .uart_rts_o(p), .uart_txd_o(~p), .uart_cts_i,
		.uart_rxd_i, .i2s1_o, .i2s1_oe, .i2s1_i, .i2s2_o, .i2s2_oe, .i2s2_i, .i2s3_o, .i2s3_oe,
		.i2s3_i, .card_clk_o(p), .card_cmd_o(~p), .card_cmd_oe(p), .card_dat_o, .card_dat_oe,
		.card_cmd_i, .card_dat_i, .gpio_out, .gpio_oe, .gpio_in);
	pfm_board_model board (.p, .pp_pin_o, .pp_pin_oe_n, .sp_pin_o, .sp_pin_oe_n, .pp_ext,
		.sp_ext, .pp_pin_i, .sp_pin_i);

	// clock and hang guard; the run needs well under 200 cycles
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycle_cnt <= cycle_cnt + 1;
		if (cycle_cnt == 1000) begin
			num_errors = num_errors + 1;
			end_of_test();
		end
	end

	task automatic tick();
		@(posedge core_clk);
		#10;
	endtask : tick
	// leaves the strobe high so writes can follow back to back
	task automatic wr(input logic [2:0] m, input logic [1:0] s);
		ebs_wr_en = 1'b1;
		ebs_wr_par = m;
		ebs_wr_ser = s;
		tick();
	endtask : wr
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// owner of a pin: kind * 32 + element; kinds disp gpio spi uart aud2 aud3 card aud1
	function automatic int own(input logic [2:0] m, input int i);
		int k;
		int j;
		k = (m == 3'h7) ? 0 : int'(m);
		j = i - 9;
		if (i > 8 && i < 17) begin
			if (k == 2) return 32 + GPH[j];
			if (j < 4 && (k == 1 || k == 4 || k == 6)) return 128 + j;
			if (j < 4 && (k == 3 || k == 5)) return 64 + SLO[j];
			if (j > 3 && (k == 1 || k == 4 || k == 5)) return 92 + j;
			if (j > 3 && (k == 3 || k == 6)) return 156 + j;
		end else if (k == 1 || k == 6) begin
			if (i < 3) return 64 + i;
			if (i > 16) return 50 + i;
			return 41 + i;
		end
		return i;
	endfunction : own
	function automatic int own_sp(input logic [1:0] s, input int i);
		if (s == 2'h2 || (s == 2'h1 && i > 3)) return 38 + i;
		if (s == 2'h1) return 224 + SAU[i];
		return 192 + i;
	endfunction : own_sp
	function automatic logic [1:0] aud(input logic [2:0] o, input logic [1:0] oe, input int x);
		if (x == 2) return 2'h2;
		if (x == 3) return {1'b0, o[2]};
		return {~oe[x], o[x]};
	endfunction : aud
	// expected {oe_n, out} of a pin from its owner
	function automatic logic [1:0] drv(input int o);
		int x;
		x = o % 32;
		case (o / 32)
			0: return {~disp_oe[x], disp_out[x]};
			1: return {~gpio_oe[x], gpio_out[x]};
			2: begin
				if (x == 1) return 2'h2;
				return {1'b0, (x == 0) ? ~p : (x == 2) ? p : spi_cs_o[x - 3]};
			end
			3: return (x == 1 || x == 2) ? 2'h2 : {1'b0, (x == 0) ? p : ~p};
			4: return aud(i2s2_o, i2s2_oe, x);
			5: return aud(i2s3_o, i2s3_oe, x);
			6: begin
				if (x == 0) return {1'b0, p};
				if (x == 1) return {~p, ~p};
				return {~card_dat_oe[x - 2], card_dat_o[x - 2]};
			end
			default: return aud(i2s1_o, i2s1_oe, x);
		endcase
	endfunction : drv
	// pins always; peripheral inputs only once the synchronisers have settled
	task automatic check_all(input logic [2:0] m, input logic [1:0] s, input bit full);
		logic [20:0] eo, en, ed;
		logic [5:0] so, sn;
		logic [31:0] eg;
		logic [2:0] e1, e2, e3;
		logic [3:0] ecd, eu;
		logic [1:0] d;
		logic w;
		int o;
		int x;
		{ed, eg, e1, e2, e3, ecd} = '0;
		eu = 4'h4;
		for (int i = 0; i < 27; i++) begin
			o = (i < 21) ? own(m, i) : own_sp(s, i - 21);
			x = o % 32;
			d = drv(o);
			w = !d[1] ? d[0] : (i < 21) ? pp_ext[i] : sp_ext[i - 21];
			if (i < 21) {en[i], eo[i]} = d;
			else {sn[i - 21], so[i - 21]} = d;
			case (o / 32)
				0: ed[x] = w;
				1: eg[x] = w;
				2: if (x == 1) eu[0] = w;
				3: if (x > 0 && x < 3) eu[x] = w;
				4: if (x < 3) e2[x] = w;
				5: if (x < 3) e3[x] = w;
				6: if (x == 1) eu[3] = w;
				   else if (x > 1) ecd[x - 2] = w;
				default: if (x < 3) e1[x] = w;
			endcase
		end
		chk("pp_pin_oe_n", en, pp_pin_oe_n);
		chk("pp_pin_o", eo & ~en, pp_pin_o & ~en);
		chk("sp_pin_oe_n", sn, sp_pin_oe_n);
		chk("sp_pin_o", so & ~sn, sp_pin_o & ~sn);
		if (full) begin
			chk("disp_in", ed, disp_in);
			chk("gpio_in", eg, gpio_in);
			chk("i2s_in", {e1, e2, e3}, {i2s1_i, i2s2_i, i2s3_i});
			chk("misc_in", {eu, ecd}, {card_cmd_i, uart_rxd_i, uart_cts_i, spi_rx_i,
				card_dat_i});
		end
	endtask : check_all
	task automatic end_of_test();
		if (num_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	// main sequence: reset, frozen write, mode sweep, back-to-back writes
	initial begin
		repeat (4) tick();
		chk("reset_oe_n", 27'h7ffffff, {sp_pin_oe_n, pp_pin_oe_n});
		chk("reset_regs", 32'h1, {parallel_port_mux_field, serial_port1_mux_field,
			pulldown_inhibit_reg_c, serial_pd_inhibit, uart_rxd_i});
		rst = 1'b0;
		ce = 1'b0;
		wr(3'h5, 2'h1);
		ebs_wr_en = 1'b0;
		ce = 1'b1;
		chk("frozen_fields", 32'h0, {parallel_port_mux_field, serial_port1_mux_field});
		pdi_wr_par = 14'h2a55;
		pdi_wr_ser = 6'h25;
		pdi_wr_en = 1'b1;
		tick();
		pdi_wr_en = 1'b0;
		for (int m = 0; m < 8; m++) begin
			wr(3'(m), 2'(m % 4));
			ebs_wr_en = 1'b0;
			chk("mode_fields", m * 4 + m % 4, {parallel_port_mux_field,
				serial_port1_mux_field});
			check_all(pm, ps, 1'b0);
			tick();
			check_all(3'(m), 2'(m % 4), 1'b0);
			// peripherals restart their patterns only once their pins have moved
			p = 1'b0;
			repeat (5) tick();
			check_all(3'(m), 2'(m % 4), 1'b1);
			p = 1'b1;
			repeat (5) tick();
			check_all(3'(m), 2'(m % 4), 1'b1);
			chk("pd_inhibit", {14'h2a55, 6'h25}, {pulldown_inhibit_reg_c,
				serial_pd_inhibit});
			{pm, ps} = {3'(m), 2'(m % 4)};
		end
		wr(3'h3, 2'h1);
		pdi_wr_par = 14'h15aa;
		pdi_wr_ser = 6'h1a;
		pdi_wr_en = 1'b1;
		wr(3'h6, 2'h2);
		ebs_wr_en = 1'b0;
		pdi_wr_en = 1'b0;
		chk("b2b_regs", {3'h6, 2'h2, 14'h15aa, 6'h1a}, {parallel_port_mux_field,
			serial_port1_mux_field, pulldown_inhibit_reg_c, serial_pd_inhibit});
		repeat (5) tick();
		check_all(3'h6, 2'h2, 1'b1);
		// reset while frozen must still clear a non-default mode and release the pins
		ce = 1'b0;
		rst = 1'b1;
		tick();
		rst = 1'b0;
		ce = 1'b1;
		chk("rst_frozen_regs", 32'h1, {parallel_port_mux_field, serial_port1_mux_field,
			pulldown_inhibit_reg_c, serial_pd_inhibit, uart_rxd_i});
		chk("rst_frozen_oe_n", 27'h7ffffff, {sp_pin_oe_n, pp_pin_oe_n});
		repeat (5) tick();
		check_all(3'h0, 2'h0, 1'b1);
		end_of_test();
	end
endmodule : pin_function_mux_tb
`default_nettype wire
